// >>> src/pefl_pkg.sv
// Package: constants and types shared by the port exception flag logic
package pefl_pkg;

  localparam int PEFL_PORTS = 4;
  localparam int PEFL_SEL_W = 2;
  localparam int PEFL_ATTEMPT_LIMIT = 16;
  localparam int PEFL_CNT_W = 5;
  localparam int PEFL_ADDR_W = 8;
  localparam int PEFL_DATA_W = 32;

  localparam logic [PEFL_ADDR_W-1:0] PEFL_OFS_STATUS = 8'h00;
  localparam logic [PEFL_ADDR_W-1:0] PEFL_OFS_CONFIG = 8'h04;
  localparam logic [PEFL_ADDR_W-1:0] PEFL_OFS_CLEAR = 8'h08;
  localparam logic [PEFL_ADDR_W-1:0] PEFL_OFS_ATTEMPTS = 8'h0c;

  localparam int PEFL_RETRY_LSB = 0;
  localparam int PEFL_DISCARD_LSB = 4;
  localparam int PEFL_FORCE_SINGLE_BIT = 0;
  localparam int PEFL_ATTEMPT_LANE_W = 8;
  localparam logic PEFL_FORCE_SINGLE_RST = 1'b0;

  localparam logic [1:0] PEFL_RESP_OKAY = 2'h0;
  localparam logic [1:0] PEFL_RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    PEFL_TX_IDLE = 1'b0,
    PEFL_TX_BUSY = 1'b1
  } pefl_tx_state_t;

endpackage : pefl_pkg

// >>> src/pefl_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pefl_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } pefl_sync_state_t;

  pefl_sync_state_t st;
  pefl_sync_state_t next_st;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("pefl_sync: WIDTH must be at least 1");
    end
  endgenerate

  always_comb begin
    next_st.stage1 = async_in;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= {RESET_VALUE, RESET_VALUE};
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stage2;
endmodule : pefl_sync
`default_nettype wire

// >>> src/pefl_port.sv
// One port's retry-request and receive-discard flags with attempt tracking
`timescale 1ns/1ps
`default_nettype none
module pefl_port
  import pefl_pkg::*;
#(
  parameter int ATTEMPT_LIMIT = pefl_pkg::PEFL_ATTEMPT_LIMIT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic single_attempt,
  input wire logic full_duplex,
  input wire logic tx_active,
  input wire logic collision,
  input wire logic late_collision,
  input wire logic carrier_sense,
  input wire logic underflow,
  input wire logic tx_end,
  input wire logic rx_drop,
  input wire logic abort_pulse,
  input wire logic clear_tx,
  input wire logic clear_rx,
  output logic retry_flag,
  output logic discard_flag,
  output logic tx_fifo_clear,
  output logic tx_start_allow,
  output logic tx_retransmit,
  output logic tx_defer_enable,
  output logic rx_fifo_clear,
  output logic rx_accept,
  output logic rx_abandon,
  output logic [pefl_pkg::PEFL_CNT_W-1:0] attempts
);
  import pefl_pkg::*;

  typedef struct packed {
    logic retry;
    logic discard;
    pefl_tx_state_t txst;
    logic crs_seen;
    logic [PEFL_CNT_W-1:0] attempts;
    logic retransmit;
    logic abandon;
  } pefl_port_state_t;

  pefl_port_state_t st;
  pefl_port_state_t next_st;
  logic busy;
  logic col;
  logic set_tx;

  generate
    if (ATTEMPT_LIMIT < 2 || ATTEMPT_LIMIT >= (1 << PEFL_CNT_W)) begin : g_bad_limit
      $error("pefl_port: ATTEMPT_LIMIT out of range");
    end
  endgenerate

  always_comb begin
    next_st = st;
    next_st.retransmit = 1'b0;
    next_st.abandon = abort_pulse;
    busy = (st.txst == PEFL_TX_BUSY);
    col = busy & collision & ~late_collision;
    set_tx = (busy & late_collision)
      | (busy & st.crs_seen & ~carrier_sense)
      | (busy & tx_end & ~st.crs_seen & ~carrier_sense)
      | (busy & underflow)
      | (col & ~single_attempt & (st.attempts == PEFL_CNT_W'(ATTEMPT_LIMIT - 1)))
      | (col & single_attempt);
    case (st.txst)
      PEFL_TX_IDLE: begin
        if (tx_active && !st.retry) begin
          next_st.txst = PEFL_TX_BUSY;
          next_st.crs_seen = carrier_sense;
        end
      end
      PEFL_TX_BUSY: begin
        next_st.crs_seen = st.crs_seen | carrier_sense;
        if (set_tx || tx_end || col || !tx_active) begin
          next_st.txst = PEFL_TX_IDLE;
        end
      end
      default: begin
        next_st.txst = PEFL_TX_IDLE;
      end
    endcase
    if (set_tx || (busy && tx_end)) begin
      next_st.attempts = '0;
    end else if (col) begin
      // Back-off and retry of the same frame only in normal mode
      next_st.attempts = st.attempts + PEFL_CNT_W'(1);
      next_st.retransmit = ~single_attempt;
    end
    // Clear acts in the cycle it is seen; a same-cycle set wins
    if (clear_tx) begin
      next_st.retry = 1'b0;
    end
    if (set_tx) begin
      next_st.retry = 1'b1;
    end
    if (clear_rx) begin
      next_st.discard = 1'b0;
    end
    if (rx_drop) begin
      next_st.discard = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign retry_flag = st.retry;
  assign discard_flag = st.discard;
  assign tx_fifo_clear = st.retry;
  assign tx_start_allow = ~st.retry;
  assign tx_retransmit = st.retransmit;
  assign tx_defer_enable = ~full_duplex;
  assign rx_fifo_clear = st.discard;
  assign rx_accept = ~st.discard;
  assign rx_abandon = st.abandon;
  assign attempts = st.attempts;

  property p_retry_sticky;
    @(posedge aclk) disable iff (!aresetn) retry_flag && !clear_tx |=> retry_flag;
  endproperty
  a_retry_sticky: assert property (p_retry_sticky) else $error("retry flag dropped without clear");

  property p_late_sets;
    @(posedge aclk) disable iff (!aresetn) busy && late_collision |=> retry_flag && tx_fifo_clear;
  endproperty
  a_late_sets: assert property (p_late_sets) else $error("late collision did not raise retry");

  property p_underflow_sets;
    @(posedge aclk) disable iff (!aresetn) busy && underflow |=> retry_flag;
  endproperty
  a_underflow_sets: assert property (p_underflow_sets) else $error("underflow did not raise retry");

  property p_single_no_retry;
    @(posedge aclk) disable iff (!aresetn)
      busy && collision && single_attempt |=> retry_flag && !tx_retransmit && !tx_start_allow;
  endproperty
  a_single_no_retry: assert property (p_single_no_retry) else $error("single attempt collision mishandled");

  property p_limit_reached;
    @(posedge aclk) disable iff (!aresetn)
      col && !single_attempt && attempts == PEFL_CNT_W'(ATTEMPT_LIMIT - 1) |=> retry_flag && attempts == '0;
  endproperty
  a_limit_reached: assert property (p_limit_reached) else $error("attempt limit did not raise retry");

  property p_no_start_flagged;
    @(posedge aclk) disable iff (!aresetn) retry_flag && !busy |=> !busy;
  endproperty
  a_no_start_flagged: assert property (p_no_start_flagged) else $error("transmission started while flagged");

  property p_set_wins;
    @(posedge aclk) disable iff (!aresetn) rx_drop && clear_rx |=> discard_flag && !rx_accept;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a same-cycle discard");

  property p_clear_rx;
    @(posedge aclk) disable iff (!aresetn) clear_rx && !rx_drop |=> !discard_flag;
  endproperty
  a_clear_rx: assert property (p_clear_rx) else $error("discard flag not cleared");
endmodule : pefl_port
`default_nettype wire

// >>> src/pefl_top.sv
// Four-port exception flag logic with pin interface and AXI4-Lite status registers
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pefl_top
  import pefl_pkg::*;
#(
  parameter int NUM_PORTS = pefl_pkg::PEFL_PORTS,
  parameter int ATTEMPT_LIMIT = pefl_pkg::PEFL_ATTEMPT_LIMIT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pefl_pkg::PEFL_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [pefl_pkg::PEFL_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [pefl_pkg::PEFL_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [pefl_pkg::PEFL_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic tx_side_enable_n,
  input wire logic rx_side_enable_n,
  input wire logic tx_error_clear,
  input wire logic rx_error_clear,
  input wire logic [pefl_pkg::PEFL_SEL_W-1:0] port_select,
  input wire logic [NUM_PORTS-1:0] receive_abort_in,
  input wire logic [NUM_PORTS-1:0] full_duplex_select_n,
  input wire logic single_attempt_select,
  input wire logic [NUM_PORTS-1:0] mac_tx_active,
  input wire logic [NUM_PORTS-1:0] mac_collision,
  input wire logic [NUM_PORTS-1:0] mac_late_collision,
  input wire logic [NUM_PORTS-1:0] mac_carrier_sense,
  input wire logic [NUM_PORTS-1:0] mac_tx_underflow,
  input wire logic [NUM_PORTS-1:0] mac_tx_end,
  input wire logic [NUM_PORTS-1:0] mac_rx_drop,
  output logic [NUM_PORTS-1:0] retry_request,
  output logic retry_request_oe_n,
  output logic [NUM_PORTS-1:0] discard_flag,
  output logic discard_flag_oe_n,
  output logic [NUM_PORTS-1:0] tx_fifo_clear,
  output logic [NUM_PORTS-1:0] tx_start_allow,
  output logic [NUM_PORTS-1:0] tx_retransmit,
  output logic [NUM_PORTS-1:0] tx_defer_enable,
  output logic [NUM_PORTS-1:0] rx_fifo_clear,
  output logic [NUM_PORTS-1:0] rx_accept,
  output logic [NUM_PORTS-1:0] rx_frame_abandon
);
  import pefl_pkg::*;

  localparam int SYNC_W = 5 + PEFL_SEL_W + 2 * NUM_PORTS;

  typedef struct packed {
    logic aw_held;
    logic [PEFL_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [PEFL_DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [PEFL_DATA_W-1:0] rdata;
    logic force_single;
    logic [NUM_PORTS-1:0] soft_tx_clear;
    logic [NUM_PORTS-1:0] soft_rx_clear;
    logic [NUM_PORTS-1:0] abort_prev;
  } pefl_top_state_t;

  pefl_top_state_t st;
  pefl_top_state_t next_st;

  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_q;
  logic tx_en_n_s;
  logic rx_en_n_s;
  logic tx_clr_s;
  logic rx_clr_s;
  logic [PEFL_SEL_W-1:0] sel_s;
  logic [NUM_PORTS-1:0] abort_s;
  logic [NUM_PORTS-1:0] fdx_n_s;
  logic single_s;
  logic single_mode;
  logic [NUM_PORTS-1:0] clear_tx_vec;
  logic [NUM_PORTS-1:0] clear_rx_vec;
  logic [NUM_PORTS-1:0] abort_pulse;
  logic [NUM_PORTS-1:0][PEFL_CNT_W-1:0] port_attempts;
  logic [PEFL_DATA_W-1:0] status_word;
  logic [PEFL_DATA_W-1:0] attempts_word;
  logic aw_take;
  logic w_take;
  logic have_aw;
  logic have_w;
  logic [PEFL_ADDR_W-1:0] wr_addr;
  logic [PEFL_DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic ar_take;

  generate
    if (NUM_PORTS != PEFL_PORTS) begin : g_bad_ports
      $error("pefl_top: NUM_PORTS must match the two-bit port select");
    end
  endgenerate

  // Every pin from the host side crosses two flops before use
  assign sync_raw = {tx_side_enable_n, rx_side_enable_n, tx_error_clear, rx_error_clear,
                     port_select, receive_abort_in, full_duplex_select_n, single_attempt_select};

  pefl_sync #(
    .WIDTH(SYNC_W),
    .RESET_VALUE({2'h3, (SYNC_W - 2)'(0)})
  ) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(sync_raw),
    .sync_out(sync_q)
  );

  assign {tx_en_n_s, rx_en_n_s, tx_clr_s, rx_clr_s, sel_s, abort_s, fdx_n_s, single_s} = sync_q;

  // Pad pull-down holds an open input low; a driven high or the force_single config bit selects one attempt
  assign single_mode = single_s | st.force_single;

  assign abort_pulse = abort_s & ~st.abort_prev;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
      assign clear_tx_vec[gi] = (tx_clr_s & (sel_s == PEFL_SEL_W'(gi))) | st.soft_tx_clear[gi];
      assign clear_rx_vec[gi] = (rx_clr_s & (sel_s == PEFL_SEL_W'(gi))) | st.soft_rx_clear[gi];

      pefl_port #(
        .ATTEMPT_LIMIT(ATTEMPT_LIMIT)
      ) u_port (
        .aclk(aclk),
        .aresetn(aresetn),
        .single_attempt(single_mode),
        .full_duplex(~fdx_n_s[gi]),
        .tx_active(mac_tx_active[gi]),
        .collision(mac_collision[gi]),
        .late_collision(mac_late_collision[gi]),
        .carrier_sense(mac_carrier_sense[gi]),
        .underflow(mac_tx_underflow[gi]),
        .tx_end(mac_tx_end[gi]),
        .rx_drop(mac_rx_drop[gi]),
        .abort_pulse(abort_pulse[gi]),
        .clear_tx(clear_tx_vec[gi]),
        .clear_rx(clear_rx_vec[gi]),
        .retry_flag(retry_request[gi]),
        .discard_flag(discard_flag[gi]),
        .tx_fifo_clear(tx_fifo_clear[gi]),
        .tx_start_allow(tx_start_allow[gi]),
        .tx_retransmit(tx_retransmit[gi]),
        .tx_defer_enable(tx_defer_enable[gi]),
        .rx_fifo_clear(rx_fifo_clear[gi]),
        .rx_accept(rx_accept[gi]),
        .rx_abandon(rx_frame_abandon[gi]),
        .attempts(port_attempts[gi])
      );
    end
  endgenerate

  // Pins drive only while the host enables them
  assign retry_request_oe_n = tx_en_n_s;
  assign discard_flag_oe_n = rx_en_n_s;

  always_comb begin
    status_word = '0;
    attempts_word = '0;
    status_word[PEFL_RETRY_LSB +: NUM_PORTS] = retry_request;
    status_word[PEFL_DISCARD_LSB +: NUM_PORTS] = discard_flag;
    for (int i = 0; i < NUM_PORTS; i++) begin
      attempts_word[i * PEFL_ATTEMPT_LANE_W +: PEFL_ATTEMPT_LANE_W] =
        {(PEFL_ATTEMPT_LANE_W - PEFL_CNT_W)'(0), port_attempts[i]};
    end
  end

  assign awready = ~st.aw_held & ~st.bvalid;
  assign wready = ~st.w_held & ~st.bvalid;
  assign arready = ~st.rvalid;

  always_comb begin
    next_st = st;
    next_st.soft_tx_clear = '0;
    next_st.soft_rx_clear = '0;
    next_st.abort_prev = abort_s;
    aw_take = awvalid & awready;
    w_take = wvalid & wready;
    ar_take = arvalid & arready;
    have_aw = st.aw_held | aw_take;
    have_w = st.w_held | w_take;
    wr_addr = st.aw_held ? st.aw_addr : awaddr;
    wr_data = st.w_held ? st.w_data : wdata;
    wr_strb = st.w_held ? st.w_strb : wstrb;
    if (aw_take) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = awaddr;
    end
    if (w_take) begin
      next_st.w_held = 1'b1;
      next_st.w_data = wdata;
      next_st.w_strb = wstrb;
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    if (have_aw && have_w && !st.bvalid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = PEFL_RESP_OKAY;
      case ({wr_addr[PEFL_ADDR_W-1:2], 2'h0})
        PEFL_OFS_STATUS: begin
        end
        PEFL_OFS_ATTEMPTS: begin
        end
        PEFL_OFS_CONFIG: begin
          if (wr_strb[0]) begin
            next_st.force_single = wr_data[PEFL_FORCE_SINGLE_BIT];
          end
        end
        PEFL_OFS_CLEAR: begin
          if (wr_strb[0]) begin
            next_st.soft_tx_clear = wr_data[PEFL_RETRY_LSB +: NUM_PORTS];
            next_st.soft_rx_clear = wr_data[PEFL_DISCARD_LSB +: NUM_PORTS];
          end
        end
        default: begin
          next_st.bresp = PEFL_RESP_SLVERR;
        end
      endcase
    end
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    if (ar_take) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = PEFL_RESP_OKAY;
      case ({araddr[PEFL_ADDR_W-1:2], 2'h0})
        PEFL_OFS_STATUS: begin
          next_st.rdata = status_word;
        end
        PEFL_OFS_CONFIG: begin
          next_st.rdata = '0;
          next_st.rdata[PEFL_FORCE_SINGLE_BIT] = st.force_single;
        end
        PEFL_OFS_CLEAR: begin
          next_st.rdata = '0;
        end
        PEFL_OFS_ATTEMPTS: begin
          next_st.rdata = attempts_word;
        end
        default: begin
          next_st.rdata = '0;
          next_st.rresp = PEFL_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.force_single <= PEFL_FORCE_SINGLE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign rvalid = st.rvalid;
  assign rresp = st.rresp;
  assign rdata = st.rdata;

  sequence s_tx_enabled;
    !tx_side_enable_n [*3];
  endsequence

  sequence s_rx_enabled;
    !rx_side_enable_n [*3];
  endsequence

  property p_tx_oe;
    @(posedge aclk) disable iff (!aresetn) s_tx_enabled |-> !retry_request_oe_n;
  endproperty
  a_tx_oe: assert property (p_tx_oe) else $error("retry outputs not driven while enabled");

  property p_tx_oe_off;
    @(posedge aclk) disable iff (!aresetn) tx_side_enable_n [*3] |-> retry_request_oe_n;
  endproperty
  a_tx_oe_off: assert property (p_tx_oe_off) else $error("retry outputs driven while disabled");

  property p_rx_oe;
    @(posedge aclk) disable iff (!aresetn) s_rx_enabled |-> !discard_flag_oe_n;
  endproperty
  a_rx_oe: assert property (p_rx_oe) else $error("discard outputs not driven while enabled");

  sequence s_tx_clear_port1;
    (tx_error_clear && port_select == 2'h1) [*3];
  endsequence

  property p_tx_clear_select;
    @(posedge aclk) disable iff (!aresetn) s_tx_clear_port1 |-> clear_tx_vec[1] && !clear_tx_vec[0];
  endproperty
  a_tx_clear_select: assert property (p_tx_clear_select) else $error("transmit clear reached wrong port");

  property p_rx_clear_select;
    @(posedge aclk) disable iff (!aresetn)
      (rx_error_clear && port_select == 2'h3) [*3] |-> clear_rx_vec[3] && !clear_rx_vec[2];
  endproperty
  a_rx_clear_select: assert property (p_rx_clear_select) else $error("receive clear reached wrong port");

  property p_abort;
    @(posedge aclk) disable iff (!aresetn) !receive_abort_in[0] ##1 receive_abort_in[0] |-> ##3 rx_frame_abandon[0];
  endproperty
  a_abort: assert property (p_abort) else $error("receive abort did not abandon frame");

  property p_abort_single;
    @(posedge aclk) disable iff (!aresetn) rx_frame_abandon[0] |=> !rx_frame_abandon[0];
  endproperty
  a_abort_single: assert property (p_abort_single) else $error("abandon pulse longer than one cycle");

  property p_duplex;
    @(posedge aclk) disable iff (!aresetn) !full_duplex_select_n[2] [*3] |-> !tx_defer_enable[2];
  endproperty
  a_duplex: assert property (p_duplex) else $error("full duplex port still defers");

  property p_single_default;
    @(posedge aclk) disable iff (!aresetn) (!single_attempt_select && !st.force_single) [*3] |-> !single_mode;
  endproperty
  a_single_default: assert property (p_single_default) else $error("single attempt mode without request");

  property p_write_answer;
    @(posedge aclk) disable iff (!aresetn) awvalid && awready && wvalid && wready |=> bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write response late");

  property p_read_answer;
    @(posedge aclk) disable iff (!aresetn) arvalid && arready |=> rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read response late");
endmodule : pefl_top
`default_nettype wire

// >>> tb/pefl_host_model.sv
// Host pin model: clear, select and enable pins, resolved flag wires
`timescale 1ns/1ps
`default_nettype none
module pefl_host_model (
  input wire logic aclk,
  input wire logic [2:0] req,
  input wire logic [1:0] sel_req,
  input wire logic [3:0] retry_request,
  input wire logic retry_request_oe_n,
  input wire logic [3:0] discard_flag,
  input wire logic discard_flag_oe_n,
  output var logic tx_error_clear = 1'h0,
  output var logic rx_error_clear = 1'h0,
  output var logic tx_side_enable_n = 1'h1,
  output var logic rx_side_enable_n = 1'h1,
  output var logic [1:0] port_select = 2'h0,
  output wire logic [3:0] retry_wire,
  output wire logic [3:0] discard_wire
);
  logic [3:0] last_rt = 4'h0;
  logic [3:0] last_dc = 4'h0;
  always @(posedge aclk) begin
    {rx_error_clear, tx_error_clear} <= req[1:0];
    {tx_side_enable_n, rx_side_enable_n} <= {2{~req[2]}};
    port_select <= sel_req;
    if (!retry_request_oe_n) last_rt <= retry_request;
    if (!discard_flag_oe_n) last_dc <= discard_flag;
  end
  // Released wire shows the inverse of its last driven value
  assign retry_wire = retry_request_oe_n ? ~last_rt : retry_request;
  assign discard_wire = discard_flag_oe_n ? ~last_dc : discard_flag;
endmodule : pefl_host_model
`default_nettype wire

// >>> tb/pefl_bench.sv
// Self-checking bench for the port exception flag logic
`timescale 1ns/1ps
`default_nettype none
module pefl_bench;
  import pefl_pkg::*;
  logic aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic single_attempt_select = '0, awready, wready, bvalid, arready, rvalid, retry_request_oe_n, discard_flag_oe_n;
  logic tx_side_enable_n, rx_side_enable_n, tx_error_clear, rx_error_clear;
  logic [2:0] req = '0;
  logic [1:0] sel_req = '0, bresp, rresp, port_select, r;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic [19:0] evv = '0;
  logic [3:0] full_duplex_select_n = '1, mac_tx_active = '0, receive_abort_in = '0, mac_carrier_sense = '0, m, ab_mask;
  logic [3:0] mac_collision, mac_late_collision, mac_tx_underflow, mac_tx_end, mac_rx_drop, retry_request;
  logic [3:0] discard_flag, tx_fifo_clear, tx_start_allow, tx_retransmit, tx_defer_enable, rx_fifo_clear;
  logic [3:0] rx_accept, rx_frame_abandon, retry_wire, discard_wire;
  int fails = 0, n_tests = 0, n_rt = 0, n_ab = 0, p, k;
  assign {mac_rx_drop, mac_collision, mac_tx_end, mac_tx_underflow, mac_late_collision} = evv;
  pefl_top #(.ATTEMPT_LIMIT(4)) u_dut (.*, .awprot(3'h0), .arprot(3'h0), .wstrb(4'hf));
  pefl_host_model u_host (.*);
  initial forever #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    n_rt += $countones(tx_retransmit);
    n_ab += $countones(rx_frame_abandon);
    ab_mask |= rx_frame_abandon;
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] v);
    int i;
    @(posedge aclk);
    {awaddr, araddr, wdata} <= {a, a, v};
    {awvalid, wvalid, bready, arvalid, rready} <= {wr, wr, wr, !wr, !wr};
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (arready) arvalid <= 1'h0;
      if ((bvalid && bready) || (rvalid && rready)) break;
    end
    d = wr ? 32'h0 : rdata;
    r = wr ? bresp : rresp;
    {bready, rready} <= 2'h0;
    fails += (i == 40);
    if (i == 40) report_and_stop();
    #1;
  endtask : axi
  // Kinds: 0 late collision, 1 underflow, 2 end without carrier, 3 collision, 4 receive drop
  task automatic ev(input int q, input int kind);
    @(posedge aclk);
    mac_tx_active[q] <= 1'h1;
    // Carrier present except for the no-carrier case and the receive drop
    mac_carrier_sense[q] <= (kind != 2 && kind != 4);
    repeat (2) @(posedge aclk);
    evv[kind*4+q] <= 1'h1;
    @(posedge aclk);
    evv <= '0;
    mac_tx_active[q] <= 1'h0;
    mac_carrier_sense <= '0;
    repeat (2) @(posedge aclk);
    #1;
  endtask : ev
  task automatic clr(input int rx, input int q);
    @(posedge aclk);
    req[rx] <= 1'h1;
    sel_req <= q[1:0];
    repeat (6) @(posedge aclk);
    req[1:0] <= 2'h0;
    repeat (4) @(posedge aclk);
    #1;
  endtask : clr
  initial begin
    void'($urandom(98947));
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    axi(0, PEFL_OFS_STATUS, 0);
    chk("status", d, 0);
    axi(0, 8'h10, 0);
    chk("bad_resp", r, PEFL_RESP_SLVERR);
    for (k = 0; k < 4; k++) begin
      // First pass pinned to port one so the select decode is exercised
      p = (k == 0) ? 1 : $urandom % 4;
      m = 4'h1 << p;
      n_rt = 0;
      if (k == 3) begin
        repeat (3) ev(p, 3);
        axi(0, PEFL_OFS_ATTEMPTS, 0);
        chk("attempts", d, 32'h3 << (8 * p));
      end
      chk("below_limit", retry_request, 0);
      ev(p, k);
      chk("retry", retry_request, m);
      chk("retx", n_rt, (k == 3) ? 3 : 0);
      chk("tx_fifo_clear", tx_fifo_clear, m);
      chk("tx_start_allow", tx_start_allow, 4'(~m));
      axi(0, PEFL_OFS_STATUS, 0);
      chk("status_retry", d, m);
      clr(0, p);
      chk("retry_clr", retry_request, 0);
    end
    $display("transmit exception tests done");
    n_rt = 0;
    @(posedge aclk);
    single_attempt_select <= 1'h1;
    ev(p, 3);
    chk("single_retry", retry_request, m);
    chk("single_retx", n_rt, 0);
    chk("single_flush", tx_fifo_clear, m);
    axi(1, PEFL_OFS_CLEAR, 32'h1 << p);
    chk("clear_resp", r, PEFL_RESP_OKAY);
    repeat (3) @(posedge aclk);
    #1;
    chk("reg_clr", retry_request, 0);
    axi(1, PEFL_OFS_CONFIG, 32'h1 << PEFL_FORCE_SINGLE_BIT);
    axi(0, PEFL_OFS_CONFIG, 0);
    chk("config", d, 32'h1 << PEFL_FORCE_SINGLE_BIT);
    $display("single attempt test done");
    // Receive corner: last port, with port zero aborted and port two in full duplex too
    p = 3;
    m = 4'h8;
    n_ab = 0;
    ab_mask = '0;
    @(posedge aclk);
    req[2] <= 1'h1;
    receive_abort_in <= m | 4'h1;
    full_duplex_select_n <= ~(m | 4'h4);
    ev(p, 4);
    chk("discard", discard_flag, m);
    chk("rx_fifo_clear", rx_fifo_clear, m);
    chk("rx_accept", rx_accept, 4'(~m));
    chk("discard_wire", discard_wire, m);
    chk("retry_wire", retry_wire, 0);
    chk("defer", tx_defer_enable, 4'(~(m | 4'h4)));
    @(posedge aclk);
    req[2] <= 1'h0;
    receive_abort_in <= '0;
    repeat (4) @(posedge aclk);
    #1;
    chk("oe_off", {retry_request_oe_n, discard_flag_oe_n}, 2'h3);
    chk("abandons", n_ab, 2);
    chk("abandon_port", ab_mask, m | 4'h1);
    clr(1, p);
    chk("discard_clr", discard_flag, 0);
    // Drop arrives while the synchronised clear is active: the set wins for that cycle
    @(posedge aclk);
    req[1] <= 1'h1;
    repeat (5) @(posedge aclk);
    evv[16 + p] <= 1'h1;
    @(posedge aclk);
    evv <= '0;
    req[1] <= 1'h0;
    #1;
    chk("set_wins", discard_flag, m);
    repeat (4) @(posedge aclk);
    #1;
    chk("held_clear", discard_flag, 0);
    $display("receive tests done");
    report_and_stop();
  end
endmodule : pefl_bench
`default_nettype wire
